// file: hdl/iimdr_regs.sv
// iimdr_regs.sv: irq enable, disable and mask registers with receive and
// transmit holding registers, behind an AXI4-Lite slave.
// assumes: controller flags and strobes arrive on aclk, one cycle pulses.
//
// How it works
// - a one written to a defined enable bit sets that mask bit, a zero leaves it.
// - a one written to a defined disable bit clears that mask bit, a zero leaves it.
// - the mask view reads one for each enabled source and is zero after reset.
// - bits 0, 1 and 2 steer transfer complete, receive ready and transmit ready.
// - bits 4, 5 and 11 steer slave addressed, general call and end of access.
// - bits 6, 8 and 9 steer overrun, not acknowledged and arbitration lost.
// - bit 10 steers clock stretch wait; bits 3, 7 and 12 to 31 do nothing.
// - the receive holding register shows the last byte in bits 7:0, zeros above.
// - the transmit holding register takes the next byte in bits 7:0, reset zero.
// - receive ready sets on a byte load and clears when the byte is read.
// - transmit ready clears on a holding write and sets when the shifter takes it.
// - the not acknowledged, overrun, general call, lost and end flags clear on status read.
`timescale 1ns/100ps
`default_nettype none
`include "iimdr_defs.svh"

module iimdr_regs (
  // clock and reset
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // axi write address
  input  wire logic [`IIMDR_AW-1:0] awaddr,
  input  wire logic                 awvalid,
  output var  logic                 awready,
  // axi write data
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  input  wire logic                 wvalid,
  output var  logic                 wready,
  // axi write response
  output var  logic [1:0]           bresp,
  output var  logic                 bvalid,
  input  wire logic                 bready,
  // axi read address
  input  wire logic [`IIMDR_AW-1:0] araddr,
  input  wire logic                 arvalid,
  output var  logic                 arready,
  // axi read data
  output var  logic [31:0]          rdata,
  output var  logic [1:0]           rresp,
  output var  logic                 rvalid,
  input  wire logic                 rready,
  // controller side
  input  wire iimdr_pkg::iimdr_ctl_t ctl,
  output var  logic [7:0]           tx_byte,
  output var  logic                 tx_hold_ready,
  // interrupt
  output var  logic                 irq
);

  // ********************************
  // declarations
  // ********************************
  iimdr_pkg::iimdr_state_t s;
  iimdr_pkg::iimdr_state_t next_s;
  logic [`IIMDR_FW-1:0]    flags;
  logic [`IIMDR_FW-1:0]    status;
  logic [`IIMDR_FW-1:0]    set_vec;
  logic [`IIMDR_FW-1:0]    clr_vec;
  logic [31:0]             wr_bits;
  logic [`IIMDR_FW-1:0]    wr_field;
  iimdr_pkg::iimdr_reg_t   wr_reg;
  iimdr_pkg::iimdr_reg_t   rd_reg;
  logic                    wr_go;
  logic                    rd_go;
  logic                    sr_rd;
  logic                    rhr_rd;
  logic                    thr_wr;
  logic [`IIMDR_FW-1:0]    w1c;

  // ********************************
  // functions
  // ********************************
  // word address to register id, low two bits ignored
  function automatic iimdr_pkg::iimdr_reg_t reg_dec(input logic [`IIMDR_AW-1:0] a);
    logic [`IIMDR_AW-1:0] w;
    w = a & `IIMDR_WORD_MASK;
    unique case (w)
      `IIMDR_OFF_STATUS: reg_dec = iimdr_pkg::REG_STATUS;
      `IIMDR_OFF_IER:    reg_dec = iimdr_pkg::REG_IER;
      `IIMDR_OFF_IDR:    reg_dec = iimdr_pkg::REG_IDR;
      `IIMDR_OFF_IMR:    reg_dec = iimdr_pkg::REG_IMR;
      `IIMDR_OFF_RHR:    reg_dec = iimdr_pkg::REG_RHR;
      `IIMDR_OFF_THR:    reg_dec = iimdr_pkg::REG_THR;
      default:           reg_dec = iimdr_pkg::REG_NONE;
    endcase
  endfunction

  // byte enables widened to a bit mask
  function automatic logic [31:0] strb_bits(input logic [3:0] st);
    strb_bits = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
  endfunction

  // ********************************
  // status view
  // ********************************
  // level sources follow the controller, sticky ones come from the bank
  always_comb begin
    status                     = flags & `IIMDR_VALID;
    status[`IIMDR_B_XFER]      = ctl.xfer_complete;
    status[`IIMDR_B_SVA]       = ctl.slave_addressed;
    status[`IIMDR_B_WAIT]      = ctl.clock_stretch_wait;
  end

  // ********************************
  // decode of the current accesses
  // ********************************
  always_comb begin
    wr_reg   = reg_dec(s.aw_addr);
    rd_reg   = reg_dec(araddr);
    wr_bits  = s.w_data & strb_bits(s.w_strb);
    wr_field = wr_bits[`IIMDR_FW-1:0] & `IIMDR_VALID;
    wr_go    = (s.wr_st == iimdr_pkg::WR_COLLECT) && s.have_aw && s.have_w;
    rd_go    = arvalid && s.ar_rdy;
    sr_rd    = rd_go && (rd_reg == iimdr_pkg::REG_STATUS);
    rhr_rd   = rd_go && (rd_reg == iimdr_pkg::REG_RHR);
    thr_wr   = wr_go && (wr_reg == iimdr_pkg::REG_THR) && s.w_strb[0];
    w1c      = (wr_go && (wr_reg == iimdr_pkg::REG_STATUS)) ?
               (wr_field & `IIMDR_COR) : '0;
  end

  // ********************************
  // flag set and clear
  // ********************************
  always_comb begin
    set_vec = '0;
    clr_vec = w1c;
    set_vec[`IIMDR_B_RX_HOLD_READY] = ctl.rx_load;
    clr_vec[`IIMDR_B_RX_HOLD_READY] = rhr_rd;
    // nack also frees the holding register
    set_vec[`IIMDR_B_TX_HOLD_READY] = ctl.tx_take | ctl.nack_evt;
    clr_vec[`IIMDR_B_TX_HOLD_READY] = thr_wr;
    // a load over an unread byte is an overrun
    set_vec[`IIMDR_B_OVR]   = ctl.rx_load & flags[`IIMDR_B_RX_HOLD_READY];
    set_vec[`IIMDR_B_NACK]  = ctl.nack_evt;
    set_vec[`IIMDR_B_GCALL] = ctl.general_call_evt;
    set_vec[`IIMDR_B_ARB]   = ctl.arb_lost_evt;
    // end of access marks the fall of slave addressed
    set_vec[`IIMDR_B_EOS]   = s.sva_prev & ~ctl.slave_addressed;
    if (sr_rd) begin
      clr_vec = clr_vec | `IIMDR_COR;
    end
  end

  iimdr_flag_bank #(
    .W   (`IIMDR_FW),
    .RST (`IIMDR_FLAG_RST)
  ) u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (set_vec),
    .clr     (clr_vec),
    .flags   (flags)
  );

  // ********************************
  // next state
  // ********************************
  always_comb begin
    next_s = s;

    // write address and data, taken in either order
    if (awvalid && s.aw_rdy) begin
      next_s.aw_addr = awaddr;
      next_s.aw_rdy  = 1'b0;
      next_s.have_aw = 1'b1;
    end
    if (wvalid && s.w_rdy) begin
      next_s.w_data  = wdata;
      next_s.w_strb  = wstrb;
      next_s.w_rdy   = 1'b0;
      next_s.have_w  = 1'b1;
    end

    // write execution and response
    unique case (s.wr_st)
      iimdr_pkg::WR_COLLECT: begin
        if (wr_go) begin
          next_s.b_vld  = 1'b1;
          next_s.b_resp = `IIMDR_RESP_OKAY;
          next_s.wr_st  = iimdr_pkg::WR_RESP;
          unique case (wr_reg)
            iimdr_pkg::REG_IER: begin
              next_s.mask = s.mask | wr_field;
            end
            iimdr_pkg::REG_IDR: begin
              next_s.mask = s.mask & ~wr_field;
            end
            iimdr_pkg::REG_THR: begin
              if (s.w_strb[0]) begin
                next_s.tx_byte = s.w_data[7:0];
              end
            end
            iimdr_pkg::REG_STATUS,
            iimdr_pkg::REG_IMR,
            iimdr_pkg::REG_RHR: begin
              // read only or handled by the flag bank
            end
            iimdr_pkg::REG_NONE: begin
              next_s.b_resp = `IIMDR_RESP_SLVERR;
            end
          endcase
        end
      end
      iimdr_pkg::WR_RESP: begin
        if (bready) begin
          next_s.b_vld   = 1'b0;
          next_s.have_aw = 1'b0;
          next_s.have_w  = 1'b0;
          next_s.aw_rdy  = 1'b1;
          next_s.w_rdy   = 1'b1;
          next_s.wr_st   = iimdr_pkg::WR_COLLECT;
        end
      end
    endcase

    // read: data sampled at the address edge, side effects there too
    if (rd_go) begin
      next_s.ar_rdy = 1'b0;
      next_s.r_vld  = 1'b1;
      next_s.r_resp = `IIMDR_RESP_OKAY;
      next_s.r_data = `IIMDR_WORD_ZERO;
      unique case (rd_reg)
        iimdr_pkg::REG_STATUS: begin
          next_s.r_data[`IIMDR_FW-1:0] = status;
        end
        iimdr_pkg::REG_IER,
        iimdr_pkg::REG_IDR: begin
          // write only, reads as zero
        end
        iimdr_pkg::REG_IMR: begin
          next_s.r_data[`IIMDR_FW-1:0] = s.mask;
        end
        iimdr_pkg::REG_RHR: begin
          next_s.r_data[7:0] = s.rx_byte;
        end
        iimdr_pkg::REG_THR: begin
          next_s.r_data[7:0] = s.tx_byte;
        end
        iimdr_pkg::REG_NONE: begin
          next_s.r_resp = `IIMDR_RESP_SLVERR;
        end
      endcase
    end else if (s.r_vld && rready) begin
      next_s.r_vld  = 1'b0;
      next_s.ar_rdy = 1'b1;
    end

    // received byte capture
    if (ctl.rx_load) begin
      next_s.rx_byte = ctl.rx_byte;
    end
    next_s.sva_prev = ctl.slave_addressed;

    // mask bit positions follow the status layout
    // one cycle behind the flags, traded for a flop-driven output
    next_s.irq = |(status & s.mask);
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.wr_st   <= iimdr_pkg::WR_COLLECT;
      s.aw_rdy  <= 1'b1;
      s.w_rdy   <= 1'b1;
      s.ar_rdy  <= 1'b1;
      s.mask    <= `IIMDR_MASK_RST;
      s.tx_byte <= `IIMDR_BYTE_RST;
      s.rx_byte <= `IIMDR_BYTE_RST;
    end else begin
      s <= next_s;
    end
  end

  // ********************************
  // outputs
  // ********************************
  always_comb begin
    awready       = s.aw_rdy;
    wready        = s.w_rdy;
    bvalid        = s.b_vld;
    bresp         = s.b_resp;
    arready       = s.ar_rdy;
    rvalid        = s.r_vld;
    rresp         = s.r_resp;
    rdata         = s.r_data;
    tx_byte       = s.tx_byte;
    tx_hold_ready = flags[`IIMDR_B_TX_HOLD_READY];
    irq           = s.irq;
  end

endmodule

`default_nettype wire

// file: pkg/iimdr_defs.svh
// iimdr_defs.svh: offsets, field positions and reset values of the
// irq mask and data register bank.
// assumes: included by bare name wherever the constants are needed.
`ifndef IIMDR_DEFS_SVH
`define IIMDR_DEFS_SVH

// ********************************
// bus geometry
// ********************************
`define IIMDR_AW          8
`define IIMDR_FW          12
`define IIMDR_WORD_MASK   8'hFC

// ********************************
// register byte offsets
// ********************************
`define IIMDR_OFF_STATUS  8'h20
`define IIMDR_OFF_IER     8'h24
`define IIMDR_OFF_IDR     8'h28
`define IIMDR_OFF_IMR     8'h2C
`define IIMDR_OFF_RHR     8'h30
`define IIMDR_OFF_THR     8'h34

// ********************************
// flag and mask bit positions
// ********************************
`define IIMDR_B_XFER      0
`define IIMDR_B_RX_HOLD_READY     1
`define IIMDR_B_TX_HOLD_READY     2
`define IIMDR_B_SVA       4
`define IIMDR_B_GCALL     5
`define IIMDR_B_OVR       6
`define IIMDR_B_NACK      8
`define IIMDR_B_ARB       9
`define IIMDR_B_WAIT      10
`define IIMDR_B_EOS       11

// ********************************
// field masks and reset values
// ********************************
`define IIMDR_VALID       12'hF77
`define IIMDR_COR         12'hB60
`define IIMDR_FLAG_RST    12'h004
`define IIMDR_MASK_RST    12'h000
`define IIMDR_BYTE_RST    8'h00
`define IIMDR_WORD_ZERO   32'h0000_0000
`define IIMDR_RESP_OKAY   2'h0
`define IIMDR_RESP_SLVERR 2'h2

`endif

// file: pkg/iimdr_pkg.sv
// iimdr_pkg.sv: types of the irq mask and data register bank.
// assumes: iimdr_defs.svh on the include path.
`include "iimdr_defs.svh"

package iimdr_pkg;

  // ********************************
  // controller side carrier
  // ********************************
  typedef struct packed {
    logic       xfer_complete;
    logic       slave_addressed;
    logic       clock_stretch_wait;
    logic       nack_evt;
    logic       general_call_evt;
    logic       arb_lost_evt;
    logic       rx_load;
    logic [7:0] rx_byte;
    logic       tx_take;
  } iimdr_ctl_t;

  // ********************************
  // states and register ids
  // ********************************
  typedef enum logic {WR_COLLECT, WR_RESP} iimdr_wr_t;

  typedef enum logic [2:0] {
    REG_STATUS, REG_IER, REG_IDR, REG_IMR, REG_RHR, REG_THR, REG_NONE
  } iimdr_reg_t;

  // ********************************
  // whole state of the top
  // ********************************
  typedef struct packed {
    iimdr_wr_t                wr_st;
    logic                     aw_rdy;
    logic                     w_rdy;
    logic                     have_aw;
    logic                     have_w;
    logic [`IIMDR_AW-1:0]     aw_addr;
    logic [31:0]              w_data;
    logic [3:0]               w_strb;
    logic                     b_vld;
    logic [1:0]               b_resp;
    logic                     ar_rdy;
    logic                     r_vld;
    logic [1:0]               r_resp;
    logic [31:0]              r_data;
    logic [`IIMDR_FW-1:0]     mask;
    logic [7:0]               rx_byte;
    logic [7:0]               tx_byte;
    logic                     sva_prev;
    logic                     irq;
  } iimdr_state_t;

endpackage

// file: hdl/iimdr_flag_bank.sv
// iimdr_flag_bank.sv: bank of sticky flags, set has priority over clear.
// assumes: set and clear come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none

module iimdr_flag_bank #(
  parameter int             W   = 12,
  parameter logic [W-1:0]   RST = '0
) (
  // clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // flag control
  input  wire logic [W-1:0] set,
  input  wire logic [W-1:0] clr,
  // flag state
  output var  logic [W-1:0] flags
);

  logic [W-1:0] next_flags;

  // ********************************
  // parameter check
  // ********************************
  if (W < 1) begin : g_bad_width
    $error("flag bank width must be at least one");
  end

  // ********************************
  // next state
  // ********************************
  // an event in the clearing cycle survives
  always_comb begin
    next_flags = set | (flags & ~clr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= RST;
    end else begin
      flags <= next_flags;
    end
  end

endmodule

`default_nettype wire

// file: tb/iimdr_regs_asserts.sv
// iimdr_regs_asserts.sv: port checker for the irq mask and data bank.
// assumes: bound to iimdr_regs, one clock, sync active low reset.
`timescale 1ns/100ps
`default_nettype none
`include "iimdr_defs.svh"

module iimdr_regs_asserts (
  // clock and reset
  input wire logic                  aclk,
  input wire logic                  aresetn,
  // axi side
  input wire logic [`IIMDR_AW-1:0]  araddr,
  input wire logic                  arvalid,
  input wire logic                  arready,
  input wire logic [31:0]           rdata,
  input wire logic                  rvalid,
  input wire logic [1:0]            bresp,
  input wire logic                  bvalid,
  input wire logic                  bready,
  // controller side and irq
  input wire iimdr_pkg::iimdr_ctl_t ctl,
  input wire logic [7:0]            tx_byte,
  input wire logic                  tx_hold_ready,
  input wire logic                  irq
);
  // ********************************
  // read address tracker
  // ********************************
  // rdata has no address of its own, so remember the taken one
  logic [`IIMDR_AW-1:0] rd_addr;
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_addr <= '0;
    else if (arvalid && arready) rd_addr <= araddr & `IIMDR_WORD_MASK;
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_rhr_upper_zero: assert property (rvalid && rd_addr == `IIMDR_OFF_RHR
    |-> rdata[31:8] == 24'h00_0000) else $error("rx holding upper bits set");
  a_wo_read_zero: assert property (rvalid && (rd_addr == `IIMDR_OFF_IER
    || rd_addr == `IIMDR_OFF_IDR) |-> rdata == 32'h0) else $error("write-only read not 0");
  a_imr_reserved: assert property (rvalid && rd_addr == `IIMDR_OFF_IMR
    |-> (rdata & 32'hFFFF_F088) == 32'h0) else $error("reserved mask bit set");
  a_thr_on_write: assert property ($changed(tx_byte) |-> $rose(bvalid))
    else $error("tx byte moved without a write");
  a_tx_hold_ready_clear: assert property ($fell(tx_hold_ready) |-> $rose(bvalid))
    else $error("tx ready cleared without a write");
  a_take_sets: assert property (ctl.tx_take |=> tx_hold_ready)
    else $error("tx ready not set by take");
  a_nack_sets: assert property (ctl.nack_evt |=> tx_hold_ready)
    else $error("tx ready not set by nack");
  a_irq_reset: assert property ($rose(aresetn) |-> !irq [*2])
    else $error("irq high with reset mask");
  a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  c_rx_irq: cover property (ctl.rx_load ##2 irq);
  c_tx_write: cover property ($fell(tx_hold_ready));
  c_imr_read: cover property (rvalid && rd_addr == `IIMDR_OFF_IMR);
endmodule

bind iimdr_regs iimdr_regs_asserts u_chk (.aclk(aclk), .aresetn(aresetn), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rvalid(rvalid), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .ctl(ctl), .tx_byte(tx_byte),
  .tx_hold_ready(tx_hold_ready), .irq(irq));
`default_nettype wire

// file: tb/tb_iimdr_regs.sv
// tb_iimdr_regs.sv: self-checking bench for the irq mask and data bank.
// assumes: iimdr_pkg compiled first, checker bound beside the design.
`timescale 1ns/100ps
`default_nettype none
`include "iimdr_defs.svh"

module tb_iimdr_regs;
  // ********************************
  // signals and design
  // ********************************
  logic                  aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]            awaddr, araddr, tx_byte;
  logic [31:0]           wdata, rdata;
  logic [3:0]            wstrb;
  logic [1:0]            bresp, rresp;
  logic                  awready, wready, bvalid, arready, rvalid, tx_hold_ready, irq;
  iimdr_pkg::iimdr_ctl_t ctl;
  int                    miscompares, tests_run, cyc;

  iimdr_regs u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .ctl(ctl), .tx_byte(tx_byte), .tx_hold_ready(tx_hold_ready), .irq(irq));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ********************************
  // helpers
  // ********************************
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hung handshake ends here rather than spinning forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      miscompares++;
      close_out();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(`IIMDR_RESP_OKAY), "bresp");
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e, "rdata");
    chk(32'(r), 32'(`IIMDR_RESP_OKAY), "rresp");
  endtask

  // one pulse set on the controller side, held for len cycles
  task automatic ev(input logic n, g, a, r, t, input int len);
    ctl.nack_evt <= n;
    ctl.general_call_evt <= g;
    ctl.arb_lost_evt <= a;
    ctl.rx_load <= r;
    ctl.tx_take <= t;
    tick(len);
    ctl.nack_evt <= 1'b0;
    ctl.general_call_evt <= 1'b0;
    ctl.arb_lost_evt <= 1'b0;
    ctl.rx_load <= 1'b0;
    ctl.tx_take <= 1'b0;
    tick(1);
  endtask

  // ********************************
  // scenarios
  // ********************************
  task automatic t_reset;
    chk(32'(irq), 32'h0, "irq");
    chk(32'(tx_hold_ready), 32'h1, "tx_hold_ready");
    rchk(`IIMDR_OFF_IMR, 32'h0);
    rchk(`IIMDR_OFF_THR, 32'h0);
    $display("test reset done");
  endtask

  task automatic t_mask;
    int          b[10] = '{0, 1, 2, 4, 5, 6, 8, 9, 10, 11};
    logic [31:0] m;
    m = 32'h0;
    foreach (b[i]) begin
      m = m | (32'h1 << b[i]);
      wr(`IIMDR_OFF_IER, 32'h1 << b[i]);
      rchk(`IIMDR_OFF_IMR, m);
    end
    wr(`IIMDR_OFF_IER, 32'hFFFF_FFFF);
    rchk(`IIMDR_OFF_IMR, 32'h0000_0F77);
    foreach (b[i]) begin
      m = m & ~(32'h1 << b[i]);
      wr(`IIMDR_OFF_IDR, 32'h1 << b[i]);
      rchk(`IIMDR_OFF_IMR, m);
    end
    wr(`IIMDR_OFF_IER, 32'h0000_0100);
    wr(`IIMDR_OFF_IDR, 32'h0);
    wr(`IIMDR_OFF_IER, 32'h0);
    rchk(`IIMDR_OFF_IMR, 32'h0000_0100);
    $display("test mask done");
  endtask

  task automatic t_wo;
    logic [31:0] d;
    logic [1:0]  r;
    rchk(`IIMDR_OFF_IER, 32'h0);
    rchk(`IIMDR_OFF_IDR, 32'h0);
    rchk(`IIMDR_OFF_IMR, 32'h0000_0100);
    rd(8'hFC, d, r);
    chk(32'(r), 32'(`IIMDR_RESP_SLVERR), "unmapped resp");
    chk(d, 32'h0, "unmapped data");
    $display("test write-only done");
  endtask

  task automatic t_rx;
    wr(`IIMDR_OFF_IDR, 32'hFFFF_FFFF);
    wr(`IIMDR_OFF_IER, 32'h0000_0002);
    ctl.rx_byte <= 8'hA5;
    ev(0, 0, 0, 1, 0, 1);
    tick(1);
    chk(32'(irq), 32'h1, "rx irq");
    rchk(`IIMDR_OFF_RHR, 32'h0000_00A5);
    tick(1);
    chk(32'(irq), 32'h0, "rx irq off");
    ctl.rx_byte <= 8'h3C;
    ev(0, 0, 0, 1, 0, 2);
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0046);
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0006);
    rchk(`IIMDR_OFF_RHR, 32'h0000_003C);
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0004);
    $display("test receive done");
  endtask

  task automatic t_tx;
    wr(`IIMDR_OFF_THR, 32'h1234_56C3);
    chk(32'(tx_byte), 32'h0000_00C3, "tx byte");
    chk(32'(tx_hold_ready), 32'h0, "tx_hold_ready low");
    rchk(`IIMDR_OFF_THR, 32'h0000_00C3);
    ev(0, 0, 0, 0, 1, 1);
    chk(32'(tx_hold_ready), 32'h1, "tx_hold_ready take");
    wr(`IIMDR_OFF_THR, 32'h0000_005A);
    ev(1, 0, 0, 0, 0, 1);
    chk(32'(tx_hold_ready), 32'h1, "tx_hold_ready nack");
    $display("test transmit done");
  endtask

  task automatic t_events;
    wr(`IIMDR_OFF_IDR, 32'hFFFF_FFFF);
    wr(`IIMDR_OFF_IER, 32'h0000_0200);
    ctl.slave_addressed <= 1'b1;
    tick(2);
    ctl.slave_addressed <= 1'b0;
    ev(1, 1, 1, 0, 0, 1);
    tick(1);
    chk(32'(irq), 32'h1, "event irq");
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0B24);
    chk(32'(irq), 32'h0, "event irq off");
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0004);
    $display("test events done");
  endtask

  // level sources reach the irq live; a write of one clears a sticky bit
  task automatic t_live;
    wr(`IIMDR_OFF_IDR, 32'hFFFF_FFFF);
    wr(`IIMDR_OFF_IER, 32'h0000_0400);
    ctl.xfer_complete <= 1'b1;
    ctl.clock_stretch_wait <= 1'b1;
    tick(3);
    chk(32'(irq), 32'h1, "wait irq");
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0405);
    ctl.xfer_complete <= 1'b0;
    ctl.clock_stretch_wait <= 1'b0;
    tick(3);
    chk(32'(irq), 32'h0, "wait irq off");
    ev(0, 1, 0, 0, 0, 1);
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0024);
    ev(0, 1, 0, 0, 0, 1);
    wr(`IIMDR_OFF_STATUS, 32'h0000_0020);
    rchk(`IIMDR_OFF_STATUS, 32'h0000_0004);
    $display("test live sources done");
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
    ctl = '0;
    cyc = 0;
    aresetn = 1'b0;
    tick(4);
    aresetn <= 1'b1;
    tick(1);
    t_reset();
    t_mask();
    t_wo();
    t_rx();
    t_tx();
    t_events();
    t_live();
    close_out();
  end
endmodule
`default_nettype wire
